/* File: hw/bptc_top.sv */
// Per-channel test pattern generation, error injection and checking.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps

// What this block does
// - Type bit picks PRBS15 or quasi-random pattern.
// - Switch off: transmit path sends pattern to line.
// - Switch on: receive path sends pattern to backplane.
// - Inject bit rising edge flips one bit.
// - Injected error follows the generating path.
// - Injection ignored while the generator is off.
// - Invert bit inverts generated and checked data.
// - Switch off: transmit inverts out, receive in.
// - Switch on: receive inverts out, transmit in.
// - Generator enable bit turns generation on, off.
module bptc_top (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Register port.
	input  wire logic [11:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Transmit path: framer data in, line data out.
	input  wire logic        tx_in_bit,
	input  wire logic        tx_in_valid,
	output logic             tx_line_bit,
	output logic             tx_line_valid,
	input  wire logic        tx_line_ready,
	// Receive path: line data in, backplane data out.
	input  wire logic        rx_in_bit,
	input  wire logic        rx_in_valid,
	output logic             rx_bp_bit,
	output logic             rx_bp_valid,
	input  wire logic        rx_bp_ready
);

	// ------------------------------------------------------------
	// Control registers.
	// ------------------------------------------------------------
	logic       pattern_type_select_r;
	logic       single_error_inject_r;
	logic       pattern_data_invert_r;
	logic       pattern_generator_enable_r;
	logic       pattern_switch_r;
	logic [7:0] reg_rdata_r;

	// Write decode, one strobe per register.
	logic wr_pattern_ctrl;
	logic wr_switch_ctrl;
	logic wr_errcnt;

	assign wr_pattern_ctrl = reg_wr && (reg_addr == bptc_pkg::PATTERN_CTRL_OFS);
	assign wr_switch_ctrl  = reg_wr && (reg_addr == bptc_pkg::SWITCH_CTRL_OFS);
	assign wr_errcnt       = reg_wr && (reg_addr == bptc_pkg::CHECK_ERRCNT_OFS);

	// ------------------------------------------------------------
	// Pattern control register.
	// ------------------------------------------------------------

	// Software-owned control bits; the inject bit also serves as the
	// remembered previous value for edge detection.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pattern_type_select_r      <= 1'h0;
			single_error_inject_r      <= 1'h0;
			pattern_data_invert_r      <= 1'h0;
			pattern_generator_enable_r <= 1'h0;
		end
		else if (wr_pattern_ctrl)
		begin
			pattern_type_select_r      <=
				reg_wdata[bptc_pkg::PATTERN_TYPE_BIT];
			single_error_inject_r      <=
				reg_wdata[bptc_pkg::ERROR_INJECT_BIT];
			pattern_data_invert_r      <=
				reg_wdata[bptc_pkg::DATA_INVERT_BIT];
			pattern_generator_enable_r <=
				reg_wdata[bptc_pkg::GEN_ENABLE_BIT];
		end
	end

	// Path switch bit.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pattern_switch_r <= bptc_pkg::SWITCH_RST;
		else if (wr_switch_ctrl)
			pattern_switch_r <= reg_wdata[bptc_pkg::PATTERN_SWITCH_BIT];
	end

	// ------------------------------------------------------------
	// Single error injection.
	// ------------------------------------------------------------
	logic inject_edge;
	logic err_pending_r;
	logic gen_push;

	// Only a 0 to 1 change of the stored bit arms an error; writing 1
	// over 1 does nothing, so software must write 0 in between.
	assign inject_edge = wr_pattern_ctrl
		&& reg_wdata[bptc_pkg::ERROR_INJECT_BIT]
		&& !single_error_inject_r;

	// One pending error is consumed by the next generated bit. A new
	// edge in the same cycle as consumption re-arms, so it is not lost.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			err_pending_r <= 1'h0;
		else if (!pattern_generator_enable_r)
			err_pending_r <= 1'h0;
		else if (inject_edge)
			err_pending_r <= 1'h1;
		else if (gen_push)
			err_pending_r <= 1'h0;
	end

	// ------------------------------------------------------------
	// Pattern generator and output buffer.
	// ------------------------------------------------------------
	logic raw_bit;
	logic gen_bit;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic fifo_out_bit;
	logic fifo_full;
	logic fifo_empty;
	logic sink_ready;
	logic fifo_flush;

	// The generator runs only while enabled and while the buffer has
	// room, so a stalled output stalls the sequence instead of
	// dropping bits from it. It also holds during a flush, because a
	// bit stepped out then would be thrown away with the stale ones.
	assign gen_push = pattern_generator_enable_r && fifo_in_ready
		&& !fifo_flush;

	bptc_gen u_gen (
		.clk      (clk),
		.rst_n    (rst_n),
		.step     (gen_push),
		.qrts_sel (pattern_type_select_r),
		.gen_bit  (raw_bit)
	);

	// Inversion and the pending error are applied before buffering.
	assign gen_bit = raw_bit
		^ pattern_data_invert_r
		^ err_pending_r;

	// Draining side follows the path that currently carries the pattern.
	assign sink_ready = pattern_switch_r ? rx_bp_ready : tx_line_ready;
	assign fifo_out_ready = sink_ready && pattern_generator_enable_r;

	// Disabling the generator or moving it to the other path flushes
	// stale bits, but after a path change the newly chosen output still shows the oldest one for one cycle.
	logic switch_d_r;

	// Delayed switch copy marks the cycle right after a path change.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			switch_d_r <= bptc_pkg::SWITCH_RST;
		else
			switch_d_r <= pattern_switch_r;
	end

	// The flush acts at the edge after the write, so it never collides
	// with the first bit buffered after the generator is turned on.
	assign fifo_flush = (switch_d_r != pattern_switch_r)
		|| !pattern_generator_enable_r;

	bptc_fifo #(
		.WIDTH (bptc_pkg::FIFO_WIDTH),
		.DEPTH (bptc_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.flush     (fifo_flush),
		.in_valid  (gen_push),
		.in_ready  (fifo_in_ready),
		.in_data   (gen_bit),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_bit),
		.full      (fifo_full),
		.empty     (fifo_empty)
	);

	// ------------------------------------------------------------
	// Path outputs.
	// ------------------------------------------------------------
	logic tx_pass_bit_r;
	logic tx_pass_valid_r;
	logic rx_pass_bit_r;
	logic rx_pass_valid_r;
	logic tx_gen_sel;
	logic rx_gen_sel;

	// Ordinary traffic is carried through one register stage.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_pass_bit_r   <= 1'h0;
			tx_pass_valid_r <= 1'h0;
			rx_pass_bit_r   <= 1'h0;
			rx_pass_valid_r <= 1'h0;
		end
		else
		begin
			tx_pass_bit_r   <= tx_in_bit;
			tx_pass_valid_r <= tx_in_valid;
			rx_pass_bit_r   <= rx_in_bit;
			rx_pass_valid_r <= rx_in_valid;
		end
	end

	// Which output is replaced by the pattern.
	assign tx_gen_sel = pattern_generator_enable_r && !pattern_switch_r;
	assign rx_gen_sel = pattern_generator_enable_r && pattern_switch_r;

	// Transmit toward the line.
	assign tx_line_bit   = tx_gen_sel ? fifo_out_bit : tx_pass_bit_r;
	assign tx_line_valid = tx_gen_sel ? fifo_out_valid
		: tx_pass_valid_r;

	// Receive toward the backplane.
	assign rx_bp_bit     = rx_gen_sel ? fifo_out_bit : rx_pass_bit_r;
	assign rx_bp_valid   = rx_gen_sel ? fifo_out_valid
		: rx_pass_valid_r;

	// ------------------------------------------------------------
	// Pattern checker.
	// ------------------------------------------------------------
	logic                        chk_bit;
	logic                        chk_valid;
	logic [bptc_pkg::LFSR_W-1:0] chk_sr_r;
	logic [4:0]                  chk_fill_r;
	logic                        chk_synced;
	logic                        chk_predict;
	logic                        chk_miss;
	logic [7:0]                  err_count_r;

	// The checker watches the path opposite the generator, with the
	// same inversion undone before comparison.
	assign chk_bit = (pattern_switch_r ? tx_in_bit : rx_in_bit)
		^ pattern_data_invert_r;
	assign chk_valid = pattern_switch_r ? tx_in_valid : rx_in_valid;

	// Self-synchronising prediction from the last received bits.
	assign chk_predict = pattern_type_select_r
		? (chk_sr_r[bptc_pkg::QRTS_TAP_A] ^ chk_sr_r[bptc_pkg::QRTS_TAP_B])
		: (chk_sr_r[bptc_pkg::PRBS_TAP_A] ^ chk_sr_r[bptc_pkg::PRBS_TAP_B]);
	assign chk_synced = (chk_fill_r == bptc_pkg::SYNC_BITS);
	assign chk_miss   = chk_valid && chk_synced && (chk_bit != chk_predict);

	// History register and fill count; any pattern control write restarts the fill,
	// because after a type change the old history predicts the wrong polynomial.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			chk_sr_r   <= '0;
			chk_fill_r <= '0;
		end
		else if (wr_pattern_ctrl)
		begin
			chk_fill_r <= '0;
		end
		else if (chk_valid)
		begin
			chk_sr_r <= {chk_sr_r[bptc_pkg::LFSR_W-2:0], chk_bit};
			if (!chk_synced)
				chk_fill_r <= chk_fill_r + 1'b1;
		end
	end

	// Saturating mismatch count; a miss in the clearing cycle counts.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			err_count_r <= bptc_pkg::ERRCNT_RST;
		else if (wr_errcnt)
			err_count_r <= chk_miss ? 8'h01 : 8'h00;
		else if (chk_miss && (err_count_r != 8'hFF))
			err_count_r <= err_count_r + 1'b1;
	end

	// ------------------------------------------------------------
	// Register read port.
	// ------------------------------------------------------------
	logic [7:0] rd_mux;

	// Unmapped addresses and unused bits read as zero.
	always_comb
	begin
		rd_mux = 8'h00;
		unique case (reg_addr)
			bptc_pkg::PATTERN_CTRL_OFS:
			begin
				rd_mux[bptc_pkg::PATTERN_TYPE_BIT] = pattern_type_select_r;
				rd_mux[bptc_pkg::ERROR_INJECT_BIT] = single_error_inject_r;
				rd_mux[bptc_pkg::DATA_INVERT_BIT]  = pattern_data_invert_r;
				rd_mux[bptc_pkg::GEN_ENABLE_BIT]   = pattern_generator_enable_r;
			end
			bptc_pkg::SWITCH_CTRL_OFS:
				rd_mux[bptc_pkg::PATTERN_SWITCH_BIT] = pattern_switch_r;
			bptc_pkg::CHECK_ERRCNT_OFS:
				rd_mux = err_count_r;
			bptc_pkg::CHECK_STATUS_OFS:
			begin
				rd_mux[bptc_pkg::STAT_SYNCED_BIT]     = chk_synced;
				rd_mux[bptc_pkg::STAT_FIFO_FULL_BIT]  = fifo_full;
				rd_mux[bptc_pkg::STAT_FIFO_EMPTY_BIT] = fifo_empty;
			end
			default:
				rd_mux = 8'h00;
		endcase
	end

	// Read data stand for exactly the cycle after the strobe.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata_r <= 8'h00;
		else
			reg_rdata_r <= reg_rd ? rd_mux : 8'h00;
	end

	assign reg_rdata = reg_rdata_r;

endmodule : bptc_top

/* File: hw/bptc_pkg.sv */
// Constants shared by the pattern test control block.
package bptc_pkg;

	// ------------------------------------------------------------
	// Register offsets (12-bit register port address).
	// ------------------------------------------------------------
	localparam logic [11:0] SWITCH_CTRL_OFS   = 12'h121;
	localparam logic [11:0] PATTERN_CTRL_OFS  = 12'h123;
	localparam logic [11:0] CHECK_ERRCNT_OFS  = 12'h12E;
	localparam logic [11:0] CHECK_STATUS_OFS  = 12'h12F;

	// ------------------------------------------------------------
	// Field positions.
	// ------------------------------------------------------------
	localparam int PATTERN_SWITCH_BIT    = 3;
	localparam int PATTERN_TYPE_BIT      = 7;
	localparam int ERROR_INJECT_BIT      = 6;
	localparam int DATA_INVERT_BIT       = 5;
	localparam int GEN_ENABLE_BIT        = 2;
	localparam int STAT_SYNCED_BIT       = 0;
	localparam int STAT_FIFO_FULL_BIT    = 1;
	localparam int STAT_FIFO_EMPTY_BIT   = 2;

	// ------------------------------------------------------------
	// Reset values.
	// ------------------------------------------------------------
	localparam logic [7:0] PATTERN_CTRL_RST = 8'h00;
	localparam logic       SWITCH_RST       = 1'h0;
	localparam logic [7:0] ERRCNT_RST       = 8'h00;

	// ------------------------------------------------------------
	// Pattern generator shape.
	// ------------------------------------------------------------
	localparam int          LFSR_W      = 20;
	localparam int          PRBS_TAP_A  = 14;
	localparam int          PRBS_TAP_B  = 13;
	localparam int          QRTS_TAP_A  = 19;
	localparam int          QRTS_TAP_B  = 16;
	localparam logic [19:0] LFSR_SEED   = 20'hFFFFF;
	localparam logic [4:0]  SYNC_BITS   = 5'h14;

	// ------------------------------------------------------------
	// Buffer between generator and output.
	// ------------------------------------------------------------
	localparam int FIFO_WIDTH = 1;
	localparam int FIFO_DEPTH = 16;

endpackage : bptc_pkg

/* File: hw/bptc_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module bptc_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 16
)(
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Synchronous flush.
	input  wire logic             flush,
	// Filling side.
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side.
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data,
	// Fill state.
	output logic                  full,
	output logic                  empty
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;

	// Handshakes; full and empty follow the occupancy count.
	assign full      = (count_r == (AW+1)'(DEPTH));
	assign empty     = (count_r == '0);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem_r[rd_ptr_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Storage has no reset; only words below the count are ever read.
	always_ff @(posedge clk)
	begin
		if (push)
			mem_r[wr_ptr_r] <= in_data;
	end

	// Pointers and occupancy.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end
		else if (flush)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			if (push && !pop)
				count_r <= count_r + 1'b1;
			else if (pop && !push)
				count_r <= count_r - 1'b1;
		end
	end

endmodule : bptc_fifo

/* File: hw/bptc_gen.sv */
// Pseudo-random pattern source with two selectable polynomials.
`timescale 1ns/1ps
module bptc_gen (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst_n,
	// Control.
	input  wire logic step,
	input  wire logic qrts_sel,
	// Pattern bit for the current step.
	output logic      gen_bit
);

	logic [bptc_pkg::LFSR_W-1:0] lfsr_r;
	logic                        fb;

	// Feedback picks the short or the long polynomial.
	assign fb = qrts_sel
		? (lfsr_r[bptc_pkg::QRTS_TAP_A] ^ lfsr_r[bptc_pkg::QRTS_TAP_B])
		: (lfsr_r[bptc_pkg::PRBS_TAP_A] ^ lfsr_r[bptc_pkg::PRBS_TAP_B]);
	assign gen_bit = fb;

	// Shift register advances one bit per accepted step.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			lfsr_r <= bptc_pkg::LFSR_SEED;
		else if (step)
			lfsr_r <= {lfsr_r[bptc_pkg::LFSR_W-2:0], fb};
	end

endmodule : bptc_gen

/* File: tb/bptc_checker.sv */
// Port-level assertions for the pattern test control block.
`timescale 1ns/1ps
module bptc_checker (
	// Clock and reset.
	input wire logic        clk,
	input wire logic        rst_n,
	// Register port.
	input wire logic [11:0] reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	// Transmit path.
	input wire logic        tx_in_bit,
	input wire logic        tx_in_valid,
	input wire logic        tx_line_bit,
	input wire logic        tx_line_valid,
	input wire logic        tx_line_ready,
	// Receive path.
	input wire logic        rx_in_bit,
	input wire logic        rx_in_valid,
	input wire logic        rx_bp_bit,
	input wire logic        rx_bp_valid,
	input wire logic        rx_bp_ready
);
	// ------------------------------------------------------------
	// Shadow of the control bits.
	// ------------------------------------------------------------
	localparam int GEN = bptc_pkg::GEN_ENABLE_BIT;
	localparam int INJ = bptc_pkg::ERROR_INJECT_BIT;
	logic [7:0] ctl_r;
	logic       sw_r;
	logic       wr_ctl;
	logic       tx_pat;
	logic       rx_pat;

	// The mux follows the registers from the write edge on.
	assign wr_ctl = reg_wr && reg_addr == bptc_pkg::PATTERN_CTRL_OFS;
	assign tx_pat = ctl_r[GEN] && !sw_r;
	assign rx_pat = ctl_r[GEN] && sw_r;

	// Shadow copies updated on the same edge as the design's registers.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctl_r <= 8'h00;
			sw_r  <= 1'h0;
		end
		else
		begin
			if (wr_ctl)
				ctl_r <= reg_wdata;
			if (reg_wr && reg_addr == bptc_pkg::SWITCH_CTRL_OFS)
				sw_r <= reg_wdata[bptc_pkg::PATTERN_SWITCH_BIT];
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	tx_pass_thru_a: assert property (!tx_pat |->
		tx_line_valid == $past(tx_in_valid) && tx_line_bit == $past(tx_in_bit))
		else $error("transmit output is not the delayed input");
	rx_pass_thru_a: assert property (!rx_pat |->
		rx_bp_valid == $past(rx_in_valid) && rx_bp_bit == $past(rx_in_bit))
		else $error("backplane output is not the delayed input");
	tx_gen_start_a: assert property (wr_ctl && reg_wdata[GEN] &&
		!ctl_r[GEN] && !sw_r ##1 !reg_wr |-> ##1 tx_line_valid)
		else $error("line pattern did not start");
	rx_gen_start_a: assert property (wr_ctl && reg_wdata[GEN] &&
		!ctl_r[GEN] && sw_r ##1 !reg_wr |-> ##1 rx_bp_valid)
		else $error("backplane pattern did not start");
	tx_stall_hold_a: assert property (tx_pat && tx_line_valid &&
		!tx_line_ready && !reg_wr |=> tx_line_valid && $stable(tx_line_bit))
		else $error("line bit lost while stalled");
	rx_stall_hold_a: assert property (rx_pat && rx_bp_valid &&
		!rx_bp_ready && !reg_wr |=> rx_bp_valid && $stable(rx_bp_bit))
		else $error("backplane bit lost while stalled");
	ctl_readback_a: assert property (reg_rd &&
		reg_addr == bptc_pkg::PATTERN_CTRL_OFS
		|=> reg_rdata == ($past(ctl_r) & 8'hE4))
		else $error("control register reads back wrong");
	sw_readback_a: assert property (reg_rd &&
		reg_addr == bptc_pkg::SWITCH_CTRL_OFS
		|=> reg_rdata == {4'h0, $past(sw_r), 3'h0})
		else $error("switch register reads back wrong");

	inject_cov: cover property (wr_ctl && reg_wdata[INJ] && !ctl_r[INJ]
		&& ctl_r[GEN]);
	tx_stall_cov: cover property (tx_pat && tx_line_valid && !tx_line_ready);
	rx_run_cov: cover property (rx_pat && rx_bp_valid && rx_bp_ready);
endmodule : bptc_checker

bind bptc_top bptc_checker u_chk (.clk(clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_in_bit(tx_in_bit),
	.tx_in_valid(tx_in_valid), .tx_line_bit(tx_line_bit),
	.tx_line_valid(tx_line_valid), .tx_line_ready(tx_line_ready),
	.rx_in_bit(rx_in_bit), .rx_in_valid(rx_in_valid), .rx_bp_bit(rx_bp_bit),
	.rx_bp_valid(rx_bp_valid), .rx_bp_ready(rx_bp_ready));

/* File: tb/bptc_line_model.sv */
// Far-side serial consumer that loops accepted bits back.
`timescale 1ns/1ps
module bptc_line_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Stream from the block.
	input wire logic data_bit,
	input wire logic data_valid,
	output logic     ready,
	// Pace control from the bench.
	input wire logic stall,
	input wire logic slow,
	// Looped-back stream toward the block.
	output logic     loop_bit,
	output logic     loop_valid
);
	logic tick_r;

	// Slow mode accepts every other cycle only.
	assign ready = rst_n && !stall && (!slow || tick_r);

	// Idle loop data shows the inverse of the last bit, never a held value.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_r     <= 1'b0;
			loop_valid <= 1'b0;
			loop_bit   <= 1'b0;
		end
		else
		begin
			tick_r     <= !tick_r;
			loop_valid <= data_valid && ready;
			loop_bit   <= (data_valid && ready) ? data_bit : !loop_bit;
		end
	end
endmodule : bptc_line_model

/* File: tb/bptc_top_bench.sv */
// Self-checking bench for the pattern test control block.
`timescale 1ns/1ps
module bptc_top_bench;
	logic clk, rst_n, reg_wr, reg_rd, sel_b;
	logic [11:0] reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, nv;
	logic tx_in_bit, tx_in_valid, tx_line_bit, tx_line_valid, tx_line_ready;
	logic rx_in_bit, rx_in_valid, rx_bp_bit, rx_bp_valid, rx_bp_ready;
	logic stall_a, stall_b, slow_a;
	logic cap[$];
	int   n_errors, cmp_count;
	localparam logic [11:0] CTL = bptc_pkg::PATTERN_CTRL_OFS;
	localparam logic [11:0] SW  = bptc_pkg::SWITCH_CTRL_OFS;
	localparam logic [11:0] CNT = bptc_pkg::CHECK_ERRCNT_OFS;
	localparam logic [11:0] STA = bptc_pkg::CHECK_STATUS_OFS;

	bptc_top uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .tx_in_bit(tx_in_bit),
		.tx_in_valid(tx_in_valid), .tx_line_bit(tx_line_bit),
		.tx_line_valid(tx_line_valid), .tx_line_ready(tx_line_ready),
		.rx_in_bit(rx_in_bit), .rx_in_valid(rx_in_valid),
		.rx_bp_bit(rx_bp_bit), .rx_bp_valid(rx_bp_valid),
		.rx_bp_ready(rx_bp_ready));
	bptc_line_model line_a (.clk(clk), .rst_n(rst_n), .data_bit(tx_line_bit),
		.data_valid(tx_line_valid), .ready(tx_line_ready), .stall(stall_a),
		.slow(slow_a), .loop_bit(rx_in_bit), .loop_valid(rx_in_valid));
	bptc_line_model line_b (.clk(clk), .rst_n(rst_n), .data_bit(rx_bp_bit),
		.data_valid(rx_bp_valid), .ready(rx_bp_ready), .stall(stall_b),
		.slow(1'b0), .loop_bit(tx_in_bit), .loop_valid(tx_in_valid));

	// Free-running 250 MHz clock.
	initial
	begin
		clk = 1'b0;
		forever #2 clk = !clk;
	end

	// Record every bit the selected far side accepts.
	always @(posedge clk)
		if (sel_b ? rx_bp_valid && rx_bp_ready : tx_line_valid && tx_line_ready)
			cap.push_back(sel_b ? rx_bp_bit : tx_line_bit);

	// ------------------------------------------------------------
	// Access and compare tasks.
	// ------------------------------------------------------------
	task automatic tally_and_finish;
		$display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e)
		begin
			$display("unexpected at %0t: got %h, wanted %h", $time, g, e);
			n_errors++;
		end
	endtask : cmp8

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [11:0] a, input logic [7:0] m,
		input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		cmp8(reg_rdata & m, e);
	endtask : rd

	// Bounded wait for captured bits; a hang ends the run.
	task automatic grab(input int n);
		int k;
		k = 0;
		while (cap.size() < n && k < 4000)
		begin
			@(posedge clk);
			k++;
		end
		if (k >= 4000)
		begin
			$display("unexpected at %0t: stream stopped", $time);
			n_errors++;
			tally_and_finish();
		end
	endtask : grab

	// Count bits that break b[n] = b[n-ta] ^ b[n-tb] ^ inv.
	task automatic stream(input logic [7:0] c, input int ta, input int tb,
		input logic inv);
		cap.delete();
		grab(30);
		wr(CTL, c);
		grab(150);
		nv = 8'h00;
		for (int n = 20; n < cap.size(); n++)
			if ((cap[n] ^ cap[n-ta] ^ cap[n-tb] ^ inv) !== 1'b0 && nv != 8'hFF)
				nv = nv + 8'h01;
	endtask : stream

	// Checker on the looped stream: clear count, then expect lock and no misses.
	task automatic chk_lock;
		wr(CNT, 8'h00);
		grab(cap.size() + 40);
		rd(CNT, 8'hFF, 8'h00);
		rd(STA, 8'h01, 8'h01);
	endtask : chk_lock

	// ------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------
	initial
	begin
		{rst_n, reg_wr, reg_rd, sel_b, stall_a, stall_b, slow_a} = 7'h00;
		reg_addr  = 12'h000;
		reg_wdata = 8'h00;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(CTL, 8'hFF, 8'h00);
		rd(SW, 8'hFF, 8'h00);
		rd(STA, 8'h06, 8'h04);
		wr(CTL, 8'hFF);
		rd(CTL, 8'hFF, 8'hE4);
		rd(12'h7FF, 8'hFF, 8'h00);
		wr(CTL, 8'h00);
		// Transmit generation into a slow line, single errors on rising edges.
		slow_a <= 1'b1;
		wr(CTL, 8'h04);
		stream(8'h04, 14, 15, 1'b0); cmp8(nv, 8'h00);
		chk_lock();
		stream(8'h44, 14, 15, 1'b0); cmp8(nv, 8'h03);
		stream(8'h44, 14, 15, 1'b0); cmp8(nv, 8'h00);
		stream(8'h04, 14, 15, 1'b0); cmp8(nv, 8'h00);
		stream(8'h44, 14, 15, 1'b0); cmp8(nv, 8'h03);
		// A rising edge while the generator is off does nothing.
		wr(CTL, 8'h00);
		wr(CTL, 8'h40);
		wr(CTL, 8'h44);
		stream(8'h44, 14, 15, 1'b0); cmp8(nv, 8'h00);
		// Inverted output, checker inverting its input.
		slow_a <= 1'b0;
		wr(CTL, 8'h00);
		wr(CTL, 8'h24);
		stream(8'h24, 14, 15, 1'b1); cmp8(nv, 8'h00);
		chk_lock();
		// Quasi-random pattern.
		wr(CTL, 8'h00);
		wr(CTL, 8'h84);
		stream(8'h84, 17, 20, 1'b0); cmp8(nv, 8'h00);
		stream(8'h84, 14, 15, 1'b0);
		cmp8({7'h00, nv == 8'h00}, 8'h00);
		// Switch on: backplane generates, inverts and takes the error.
		wr(CTL, 8'h00);
		wr(SW, 8'h08);
		sel_b <= 1'b1;
		wr(CTL, 8'h24);
		stream(8'h64, 14, 15, 1'b1); cmp8(nv, 8'h03);
		chk_lock();
		// Stalled backplane fills the buffer and loses nothing.
		stall_b <= 1'b1;
		repeat (40) @(posedge clk);
		rd(STA, 8'h06, 8'h02);
		stall_b <= 1'b0;
		stream(8'h24, 14, 15, 1'b1); cmp8(nv, 8'h00);
		wr(CTL, 8'h00);
		rd(STA, 8'h04, 8'h04);
		tally_and_finish();
	end
endmodule : bptc_top_bench
